// [rtl/vrl_avalon_slave.sv]
`timescale 1ns/1ps
// Avalon-MM slave, one wait cycle per access
module vrl_avalon_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic accept,
  output logic isWrite
);

  vrl_pkg::vrl_bus_e state_r;

  // ------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= vrl_pkg::BUS_IDLE;
    end else if (clkEn) begin
      case (state_r)
        vrl_pkg::BUS_IDLE: begin
          if (read || write) begin
            state_r <= vrl_pkg::BUS_ACK;
          end
        end
        vrl_pkg::BUS_ACK: begin
          state_r <= vrl_pkg::BUS_IDLE;
        end
        default: begin
          state_r <= vrl_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Wait lifted in the second cycle of a request
  assign accept = clkEn && (state_r == vrl_pkg::BUS_ACK) && (read || write);
  assign waitrequest = !accept;
  assign isWrite = write;

endmodule

// [rtl/vrl_ladder_ctrl.sv]
`timescale 1ns/1ps
// How it works
// - bit 7 powers ladder on or off
// - bit 6 connects reference to pin
// - pin drive overrides port direction bit
// - bit 5 picks low or high range
// - bit 4 picks external or supply source
// - low four bits give level code
// - reset clears power, pin, range, level
// - wake from sleep keeps register intact
// - ladder works whatever comparator mode is
// - reference feeds comparators only in mode 110
module vrl_ladder_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleepWake,
  input wire logic portADirTwo,
  input wire logic portAOutTwo,
  output logic ladderPowerOn_r,
  output logic ladderRangeSel_r,
  output logic ladderSourceSel_r,
  output logic [3:0] ladderLevelCode_r,
  output logic refToComparators_r,
  output logic pinAnalogConnect_r,
  output logic pinOutEn_n_r,
  output logic pinOut_r
);

  vrl_pkg::vrl_ctrl_s ctrl_r;
  logic [2:0] modeCode_r;
  logic accept;
  logic isWrite;
  logic ctrlHit;
  logic modeHit;
  logic statHit;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // One compare, shared by the write strobes and the checks
  function automatic logic reg_hit(input logic [3:0] addr,
                                   input logic [3:0] offset);
    return addr == offset;
  endfunction

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  vrl_avalon_slave u_slave (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .address(avs_address),
    .read(avs_read),
    .write(avs_write),
    .waitrequest(avs_waitrequest),
    .accept(accept),
    .isWrite(isWrite)
  );

  assign ctrlHit = reg_hit(avs_address, vrl_pkg::CTRL_OFFSET);
  assign modeHit = reg_hit(avs_address, vrl_pkg::MODE_OFFSET);
  assign statHit = reg_hit(avs_address, vrl_pkg::STAT_OFFSET);

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  // Sleep wake is deliberately not an input to this register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= vrl_pkg::CTRL_RESET;
    end else if (clkEn && accept && isWrite && ctrlHit
                 && avs_byteenable[0]) begin
      ctrl_r <= avs_writedata[7:0];
    end
  end

  // Comparator mode mirror, read back at the mode offset and used to route the reference
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeCode_r <= vrl_pkg::MODE_RESET;
    end else if (clkEn && accept && isWrite && modeHit
                 && avs_byteenable[0]) begin
      modeCode_r <= avs_writedata[2:0];
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Loaded in the wait cycle, so it already stands at the accept edge
  // Status lags a mode write by a clock; a read right after sees old
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= vrl_pkg::UNMAPPED_DATA;
    end else if (clkEn && avs_read && avs_waitrequest) begin
      case (avs_address)
        vrl_pkg::CTRL_OFFSET: begin
          avs_readdata <= {24'h000000, ctrl_r};
        end
        vrl_pkg::MODE_OFFSET: begin
          avs_readdata <= {29'h0, modeCode_r};
        end
        vrl_pkg::STAT_OFFSET: begin
          avs_readdata <= {31'h0, refToComparators_r};
        end
        default: begin
          avs_readdata <= vrl_pkg::UNMAPPED_DATA;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Analog control outputs
  // ------------------------------------------------------------
  // Static copies; mode code never gates them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ladderPowerOn_r <= 1'b0;
      ladderRangeSel_r <= 1'b0;
      ladderSourceSel_r <= 1'b0;
      ladderLevelCode_r <= 4'h0;
    end else if (clkEn) begin
      ladderPowerOn_r <= ctrl_r.ladderPowerOn;
      ladderRangeSel_r <= ctrl_r.ladderRangeSel;
      ladderSourceSel_r <= ctrl_r.ladderSourceSel;
      ladderLevelCode_r <= ctrl_r.ladderLevelCode;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refToComparators_r <= 1'b0;
    end else if (clkEn) begin
      refToComparators_r <= modeCode_r == vrl_pkg::MODE_MUX4;
    end
  end

  vrl_pin_mux u_pin (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .refPinDrive(ctrl_r.refPinDrive),
    .portDirIn(portADirTwo),
    .portOut(portAOutTwo),
    .pinAnalogConnect_r(pinAnalogConnect_r),
    .pinOutEn_n_r(pinOutEn_n_r),
    .pinOut_r(pinOut_r)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_power_follows_bit: assert property (
    @(posedge clk) disable iff (sys_rst)
    clkEn |=> ladderPowerOn_r == $past(ctrl_r.ladderPowerOn))
    else $error("power output does not follow control bit");

  chk_write_lands: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept && isWrite && ctrlHit && avs_byteenable[0])
    |=> ctrl_r == $past(avs_writedata[7:0]))
    else $error("control write not stored");

  chk_level_code: assert property (
    @(posedge clk) disable iff (sys_rst)
    clkEn |=> ladderLevelCode_r == $past(ctrl_r.ladderLevelCode))
    else $error("level code output wrong");

  chk_range_source: assert property (
    @(posedge clk) disable iff (sys_rst)
    clkEn |=> ladderRangeSel_r == $past(ctrl_r.ladderRangeSel)
      && ladderSourceSel_r == $past(ctrl_r.ladderSourceSel))
    else $error("range or source output wrong");

  chk_sleep_keeps: assert property (
    @(posedge clk) disable iff (sys_rst)
    (sleepWake && !(accept && isWrite)) |=> $stable(ctrl_r))
    else $error("wake changed control register");

  chk_mode_route: assert property (
    @(posedge clk) disable iff (sys_rst)
    clkEn |=> refToComparators_r == ($past(modeCode_r) == 3'h6))
    else $error("reference routing wrong");

  chk_power_any_mode: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clkEn && ctrl_r.ladderPowerOn && modeCode_r == 3'h7)
    |=> ladderPowerOn_r)
    else $error("power gated by comparator mode");

  chk_read_back: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept && !isWrite && ctrlHit)
    |-> avs_readdata == {24'h000000, ctrl_r})
    else $error("read back mismatch");

  chk_reset_clear: assert property (
    @(posedge clk) $fell(sys_rst) |-> ctrl_r == 8'h00)
    else $error("reset did not clear control");

  chk_reset_outputs: assert property (
    @(posedge clk) $fell(sys_rst)
    |-> !ladderPowerOn_r && !pinAnalogConnect_r
      && !ladderRangeSel_r && ladderLevelCode_r == 4'h0)
    else $error("reset did not clear ladder outputs");

  chk_route_reset: assert property (
    @(posedge clk) $fell(sys_rst)
    |-> !refToComparators_r && modeCode_r == vrl_pkg::MODE_RESET)
    else $error("reset left reference routed");

  chk_mode_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept && isWrite && modeHit && avs_byteenable[0])
    |=> modeCode_r == $past(avs_writedata[2:0]))
    else $error("mode write not stored");

  chk_lane_refused: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept && isWrite && !avs_byteenable[0])
    |=> $stable(ctrl_r) && $stable(modeCode_r))
    else $error("write with lane zero off changed a register");

  chk_write_only_ctrl: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept && isWrite && !ctrlHit) |=> $stable(ctrl_r))
    else $error("write elsewhere changed control");

  chk_unmapped_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept && !isWrite && !ctrlHit && !modeHit && !statHit)
    |-> avs_readdata == vrl_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");

  chk_read_only_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept && isWrite) |=> $stable(avs_readdata))
    else $error("write disturbed read data");

  // ------------------------------------------------------------
  // Handshake and freeze checks
  // ------------------------------------------------------------
  chk_wait_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(avs_read || avs_write) |-> avs_waitrequest)
    else $error("wait lifted with no request");

  chk_wait_single: assert property (
    @(posedge clk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("wait lifted for two cycles");

  chk_wait_frozen: assert property (
    @(posedge clk) disable iff (sys_rst)
    !clkEn |-> avs_waitrequest)
    else $error("bus answered while clock enable low");

  chk_state_frozen: assert property (
    @(posedge clk) disable iff (sys_rst)
    !clkEn |=> $stable(ctrl_r) && $stable(modeCode_r)
      && $stable(ladderPowerOn_r) && $stable(avs_readdata))
    else $error("state moved while clock enable low");

  // ------------------------------------------------------------
  // Pin checks
  // ------------------------------------------------------------
  chk_pin_connect: assert property (
    @(posedge clk) disable iff (sys_rst)
    clkEn |=> pinAnalogConnect_r == $past(ctrl_r.refPinDrive))
    else $error("pin connect does not follow control bit");

  chk_pin_enable: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clkEn && !ctrl_r.refPinDrive)
    |=> pinOutEn_n_r == $past(portADirTwo))
    else $error("pin enable does not follow direction bit");

  chk_pin_out_copy: assert property (
    @(posedge clk) disable iff (sys_rst)
    clkEn |=> pinOut_r == $past(portAOutTwo))
    else $error("pin data does not follow port data");

  cov_write_ctrl: cover property (
    @(posedge clk) accept && isWrite && ctrlHit);
  cov_read_ctrl: cover property (
    @(posedge clk) accept && !isWrite && ctrlHit);
  cov_pin_drive: cover property (
    @(posedge clk) pinAnalogConnect_r && !portADirTwo);
  cov_mode_mux: cover property (
    @(posedge clk) refToComparators_r && ladderPowerOn_r);
  cov_wake_off: cover property (
    @(posedge clk) sleepWake && !ladderPowerOn_r);

endmodule

// [rtl/vrl_pin_mux.sv]
`timescale 1ns/1ps
// Pin two of port A: reference drive beats the port direction bit
module vrl_pin_mux (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic refPinDrive,
  input wire logic portDirIn,
  input wire logic portOut,
  output logic pinAnalogConnect_r,
  output logic pinOutEn_n_r,
  output logic pinOut_r
);

  // ------------------------------------------------------------
  // Pin steering
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinAnalogConnect_r <= 1'b0;
      pinOutEn_n_r <= 1'b1;
      pinOut_r <= 1'b0;
    end else if (clkEn) begin
      pinAnalogConnect_r <= refPinDrive;
      // Digital driver released whenever reference owns the pin
      pinOutEn_n_r <= refPinDrive | portDirIn;
      pinOut_r <= portOut;
    end
  end

  chk_pin_override: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clkEn && refPinDrive) |=> pinOutEn_n_r && pinAnalogConnect_r)
    else $error("pin drive did not override direction");

endmodule

// [rtl/vrl_pkg.sv]
package vrl_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] MODE_OFFSET = 4'h4;
  localparam logic [3:0] STAT_OFFSET = 4'h8;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int POWER_BIT = 7;
  localparam int PIN_BIT = 6;
  localparam int RANGE_BIT = 5;
  localparam int SOURCE_BIT = 4;
  localparam int LEVEL_MSB = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] MODE_RESET = 3'h7;
  localparam logic [2:0] MODE_MUX4 = 3'h6;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic ladderPowerOn;
    logic refPinDrive;
    logic ladderRangeSel;
    logic ladderSourceSel;
    logic [3:0] ladderLevelCode;
  } vrl_ctrl_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } vrl_bus_e;

endpackage

// [test/voltage_ref_ladder_control_bench.sv]
`timescale 1ns/1ps
module voltage_ref_ladder_control_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writeData = 32'h00000000;
  logic [3:0] byteEnable = 4'hF;
  logic [31:0] readData;
  logic waitReq;
  logic sleepWake = 1'b0;
  logic portDir = 1'b0;
  logic portOut = 1'b0;
  logic powerOn, rangeSel, sourceSel, toComp, pinConn, pinOen, pinOut;
  logic [3:0] levelCode;
  int errors = 0;
  int numChecks = 0;

  vrl_ladder_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .avs_address(address), .avs_read(read), .avs_write(write),
    .avs_writedata(writeData), .avs_byteenable(byteEnable),
    .avs_readdata(readData), .avs_waitrequest(waitReq),
    .sleepWake(sleepWake), .portADirTwo(portDir), .portAOutTwo(portOut),
    .ladderPowerOn_r(powerOn), .ladderRangeSel_r(rangeSel),
    .ladderSourceSel_r(sourceSel), .ladderLevelCode_r(levelCode),
    .refToComparators_r(toComp), .pinAnalogConnect_r(pinConn),
    .pinOutEn_n_r(pinOen), .pinOut_r(pinOut));

  always #10 clk = ~clk;

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (errors == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Field order follows the register, so the byte itself is the expectation
  function automatic logic [31:0] expFields(input logic [7:0] c);
    vrl_pkg::vrl_ctrl_s s;
    s = c;
    return {24'h000000, s};
  endfunction

  function automatic logic [31:0] expPin(input logic [7:0] c, input logic d);
    return {31'h0, c[vrl_pkg::PIN_BIT] | d};
  endfunction

  task automatic check_outs(input logic [7:0] c);
    check({24'h0, powerOn, pinConn, rangeSel, sourceSel, levelCode},
      expFields(c));
    check({31'h0, pinOen}, expPin(c, portDir));
    check({31'h0, pinOut}, {31'h0, portOut});
  endtask

  // Called right after a rising edge; returns one edge past the accept
  task automatic bus(input logic wr, input logic [3:0] addr,
                     input logic [31:0] data, output logic [31:0] rd);
    address <= addr;
    writeData <= data;
    write <= wr;
    read <= !wr;
    // Only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (waitReq !== 1'b0);
    rd = readData;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic [7:0] v;
    void'($urandom(32'h6505128F));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 check_outs(8'h00);
    @(posedge clk);
    bus(1'b0, vrl_pkg::CTRL_OFFSET, 32'h0, rd);
    check(rd, {24'h0, vrl_pkg::CTRL_RESET});
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h40 : 8'($urandom);
      // Last value keeps the ladder powered through the mode sweep
      if (i == 23) begin
        v[vrl_pkg::POWER_BIT] = 1'b1;
      end
      portDir <= (i == 1) ? 1'b0 : 1'($urandom);
      portOut <= 1'($urandom);
      bus(1'b1, vrl_pkg::CTRL_OFFSET, ($urandom & 32'hFFFFFF00) | v, rd);
      #1 check_outs(v);
      @(posedge clk);
      bus(1'b0, vrl_pkg::CTRL_OFFSET, 32'h0, rd);
      check(rd, {24'h0, v});
    end
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, vrl_pkg::MODE_OFFSET, 32'(m), rd);
      #1 check({31'h0, toComp}, {31'h0, m == 6});
      check_outs(v);
      @(posedge clk);
      bus(1'b0, vrl_pkg::STAT_OFFSET, 32'h0, rd);
      check({31'h0, rd[0]}, {31'h0, m == 6});
    end
    v[vrl_pkg::POWER_BIT] = 1'b0;
    bus(1'b1, vrl_pkg::CTRL_OFFSET, {24'h0, v}, rd);
    sleepWake <= 1'b1;
    @(posedge clk);
    sleepWake <= 1'b0;
    clkEn <= 1'b0;
    portOut <= !portOut;
    repeat (3) @(posedge clk);
    #1 check({31'h0, pinOut}, {31'h0, !portOut});
    @(posedge clk);
    clkEn <= 1'b1;
    @(posedge clk);
    #1 check_outs(v);
    @(posedge clk);
    // Refused writes: unmapped place and lane zero disabled
    bus(1'b1, 4'hC, 32'h000000AA, rd);
    byteEnable <= 4'hE;
    bus(1'b1, vrl_pkg::CTRL_OFFSET, {24'h0, ~v}, rd);
    byteEnable <= 4'hF;
    bus(1'b0, 4'hC, 32'h0, rd);
    check(rd, vrl_pkg::UNMAPPED_DATA);
    bus(1'b0, vrl_pkg::CTRL_OFFSET, 32'h0, rd);
    check(rd, {24'h0, v});
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 check_outs(8'h00);
    @(posedge clk);
    bus(1'b0, vrl_pkg::MODE_OFFSET, 32'h0, rd);
    check(rd, {29'h0, vrl_pkg::MODE_RESET});
    print_verdict();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #(20 * 5000);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
